/* File: hdl/ptr_initiator.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Pointers grouped as command, status, data
// - Exactly one active pointer group
// - At most fifteen saved groups
// - Active kept until new task; good status advances
// - Failed task: restart, sense, or skip
// - Target sends restore on data-out parity error
// - Restore loads task start values
// - One saved group per active target; code gives target id 15 none
// - Saved cmd/status at start; data anywhere
// - Disconnect resets saved cmd/status to start
// - Save-data copies data pointer to saved
// - Reconnect loads saved group into active
// - Unsaved data pointer resumes at start
// - Modify-data adds signed value to saved data pointer
// - Data pointer is not a transfer count
// - Duplicate nexus is incorrect connection
// - Incorrect connection aborts, check condition sense
// - Unexpected reselection answered with abort task
module ptr_initiator (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // Link
  ptr_link_if.initiator                  link,
  // Task control
  input  wire logic                      task_load,
  input  wire logic [ptr_pkg::ID_W-1:0]  task_target,
  input  wire logic [ptr_pkg::TAG_W-1:0] task_tag,
  input  wire ptr_pkg::ptr_set_s         task_start,
  input  wire logic                      task_retry,
  input  wire logic                      send_abort_msg,
  // Status
  output ptr_pkg::ptr_set_s              active_ptr,
  output logic [ptr_pkg::ID_W-1:0]       active_target,
  output logic                           connected,
  output logic                           good_status,
  output logic [ptr_pkg::NUM_SAVED-1:0]  saved_valid
);

  localparam int ID_W = ptr_pkg::ID_W;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    ptr_pkg::ptr_set_s                       act;
    ptr_pkg::ptr_set_s                       start;
    logic [ptr_pkg::ID_W-1:0]                tgt;
    logic                                    conn;
    logic                                    good;
    logic                                    sel;
    logic [ptr_pkg::ID_W-1:0]                sel_tgt;
    logic [ptr_pkg::TAG_W-1:0]               sel_tag;
    logic                                    sel_abort;
    logic                                    abort;
    logic [ptr_pkg::ID_W-1:0]                abort_tgt;
    logic [ptr_pkg::NUM_SAVED-1:0]           sv_valid;
    ptr_pkg::ptr_set_s [ptr_pkg::NUM_SAVED-1:0] saved;
    // Start values per slot, for restore after reconnect
    ptr_pkg::ptr_set_s [ptr_pkg::NUM_SAVED-1:0] first;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic   hit;
  logic   new_slot;

  // ****************************************************************
  // Slot lookups
  // ****************************************************************
  // Id 15 owns no saved group
  assign new_slot = task_target < ID_W'(ptr_pkg::NUM_SAVED);
  // Reselect hits only a slot that holds a live task
  assign hit      = (link.ev_target < ID_W'(ptr_pkg::NUM_SAVED)) && s_q.sv_valid[link.ev_target];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d       = s_q;
    // Selection, status and abort are one-cycle pulses
    s_d.sel   = 1'b0;
    s_d.good  = 1'b0;
    s_d.abort = 1'b0;
    // ****************************************************************
    // Task load and retry
    // ****************************************************************
    // A load while a target is connected is dropped
    if (task_load && !s_q.conn) begin
      s_d.act       = task_start;
      s_d.start     = task_start;
      s_d.tgt       = task_target;
      s_d.conn      = 1'b1;
      s_d.sel       = 1'b1;
      s_d.sel_tgt   = task_target;
      s_d.sel_tag   = task_tag;
      s_d.sel_abort = send_abort_msg;
      if (new_slot) begin
        s_d.sv_valid[task_target] = 1'b1;
        s_d.saved[task_target]    = task_start;
        s_d.first[task_target]    = task_start;
      end
    end else if (task_retry) begin
      // Rerun the task from its first bytes
      s_d.act = s_q.start;
    end

    // ****************************************************************
    // Byte transfers
    // ****************************************************************
    // Counts run only while a target is connected
    if (link.xfer_valid && s_q.conn) begin
      case (link.xfer_ph)
        ptr_pkg::PH_CMD:    s_d.act.cmd    = s_q.act.cmd + 16'h0001;
        ptr_pkg::PH_STATUS: s_d.act.status = s_q.act.status + 16'h0001;
        ptr_pkg::PH_DATA:   s_d.act.data   = s_q.act.data + 16'h0001;
        default: ;
      endcase
    end

    // ****************************************************************
    // Link events
    // ****************************************************************
    if (link.ev_valid) begin
      case (link.ev)
        ptr_pkg::EV_DISCONNECT: begin
          // Saved cmd and status return to the task start
          if (s_q.conn && s_q.tgt < ID_W'(ptr_pkg::NUM_SAVED)) begin
            s_d.saved[s_q.tgt].cmd    = s_q.start.cmd;
            s_d.saved[s_q.tgt].status = s_q.start.status;
          end
          s_d.conn = 1'b0;
        end
        ptr_pkg::EV_SAVE_DATA: begin
          // Only the data pointer moves into the saved group
          if (s_q.conn && s_q.tgt < ID_W'(ptr_pkg::NUM_SAVED)) begin
            s_d.saved[s_q.tgt].data = s_q.act.data;
          end
        end
        ptr_pkg::EV_MODIFY_DATA: begin
          // Data pointer may move back: never a byte count
          if (s_q.conn && s_q.tgt < ID_W'(ptr_pkg::NUM_SAVED)) begin
            s_d.saved[s_q.tgt].data = s_q.saved[s_q.tgt].data + link.ev_arg;
          end
        end
        ptr_pkg::EV_RESTORE: begin
          // Back to the task's first bytes, not the saved group
          if (s_q.conn) begin
            s_d.act = s_q.start;
          end
        end
        ptr_pkg::EV_RESELECT: begin
          if (hit) begin
            // Resume where the target left off
            s_d.act   = s_q.saved[link.ev_target];
            s_d.start = s_q.first[link.ev_target];
            s_d.tgt   = link.ev_target;
            s_d.conn  = 1'b1;
          end else begin
            // No nexus for this target: ask it to abort
            s_d.abort     = 1'b1;
            s_d.abort_tgt = link.ev_target;
          end
        end
        ptr_pkg::EV_GOOD_STATUS: begin
          // Task closes and its slot is freed
          s_d.good = 1'b1;
          if (s_q.tgt < ID_W'(ptr_pkg::NUM_SAVED)) begin
            s_d.sv_valid[s_q.tgt] = 1'b0;
          end
          s_d.conn = 1'b0;
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output comes straight from the state register
  assign active_ptr         = s_q.act;
  assign active_target      = s_q.tgt;
  assign connected          = s_q.conn;
  assign good_status        = s_q.good;
  assign saved_valid        = s_q.sv_valid;
  assign link.sel_valid     = s_q.sel;
  assign link.sel_target    = s_q.sel_tgt;
  assign link.sel_tag       = s_q.sel_tag;
  assign link.sel_abort_msg = s_q.sel_abort;
  assign link.abort_task    = s_q.abort;
  assign link.abort_target  = s_q.abort_tgt;

endmodule
`default_nettype wire

/* File: hdl/ptr_target.sv */
`timescale 1ns/100ps
`default_nettype none
module ptr_target (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // Link
  ptr_link_if.target                      link,
  // Device requests
  input  wire logic                       req_valid,
  input  wire ptr_pkg::link_ev_e          req_ev,
  input  wire logic [ptr_pkg::ID_W-1:0]   req_target,
  input  wire logic [ptr_pkg::PTR_W-1:0]  req_arg,
  input  wire logic                       xfer_req,
  input  wire ptr_pkg::xfer_ph_e          xfer_ph_req,
  input  wire logic                       data_parity_err,
  // Nexus status
  output logic                            check_cond,
  output logic [7:0]                      sense_key,
  output logic [ptr_pkg::TAG_W-1:0]       sense_qual,
  output logic                            aborted_all,
  output logic                            nexus_open
);

  typedef struct packed {
    logic                      evv;
    ptr_pkg::link_ev_e         ev;
    logic [ptr_pkg::ID_W-1:0]  evt;
    logic [ptr_pkg::PTR_W-1:0] arg;
    logic                      xv;
    ptr_pkg::xfer_ph_e         xph;
    logic                      open;
    logic [ptr_pkg::TAG_W-1:0] tag;
    logic                      cc;
    logic [7:0]                key;
    logic [ptr_pkg::TAG_W-1:0] qual;
    logic                      abrt;
  } state_s;

  state_s s_q;
  state_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.evv  = 1'b0;
    s_d.xv   = xfer_req;
    s_d.xph  = xfer_ph_req;
    s_d.abrt = 1'b0;
    if (data_parity_err) begin
      s_d.evv = 1'b1;
      s_d.ev  = ptr_pkg::EV_RESTORE;
      s_d.evt = req_target;
      s_d.xv  = 1'b0;
    end else if (req_valid) begin
      s_d.evv = 1'b1;
      s_d.ev  = req_ev;
      s_d.evt = req_target;
      s_d.arg = req_arg;
    end
    if (link.sel_valid) begin
      if (s_q.open && !link.sel_abort_msg) begin
        s_d.cc   = 1'b1;
        s_d.key  = ptr_pkg::SENSE_ABORTED;
        s_d.qual = link.sel_tag;
        s_d.abrt = 1'b1;
        s_d.open = 1'b0;
      end else begin
        s_d.cc   = 1'b0;
        s_d.open = 1'b1;
        s_d.tag  = link.sel_tag;
      end
    end else if (link.abort_task || (req_valid && req_ev == ptr_pkg::EV_GOOD_STATUS)) begin
      s_d.open = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.ev_valid   = s_q.evv;
  assign link.ev         = s_q.ev;
  assign link.ev_target  = s_q.evt;
  assign link.ev_arg     = s_q.arg;
  assign link.xfer_valid = s_q.xv;
  assign link.xfer_ph    = s_q.xph;
  assign check_cond      = s_q.cc;
  assign sense_key       = s_q.key;
  assign sense_qual      = s_q.qual;
  assign aborted_all     = s_q.abrt;
  assign nexus_open      = s_q.open;

endmodule
`default_nettype wire

/* File: include/ptr_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ptr_link_if;
  logic                     ev_valid;
  ptr_pkg::link_ev_e        ev;
  logic [ptr_pkg::ID_W-1:0] ev_target;
  logic [ptr_pkg::PTR_W-1:0] ev_arg;
  logic                     xfer_valid;
  ptr_pkg::xfer_ph_e        xfer_ph;
  logic                     sel_valid;
  logic [ptr_pkg::ID_W-1:0] sel_target;
  logic [ptr_pkg::TAG_W-1:0] sel_tag;
  logic                     sel_abort_msg;
  logic                     abort_task;
  logic [ptr_pkg::ID_W-1:0] abort_target;

  modport target (
    output ev_valid, ev, ev_target, ev_arg, xfer_valid, xfer_ph,
    input  sel_valid, sel_target, sel_tag, sel_abort_msg, abort_task, abort_target
  );
  modport initiator (
    input  ev_valid, ev, ev_target, ev_arg, xfer_valid, xfer_ph,
    output sel_valid, sel_target, sel_tag, sel_abort_msg, abort_task, abort_target
  );
endinterface
`default_nettype wire

/* File: include/ptr_pkg.sv */
`default_nettype none
package ptr_pkg;

  // ****************************************************************
  // Widths and limits
  // ****************************************************************
  localparam int PTR_W     = 16;
  localparam int ID_W      = 4;
  localparam int TAG_W     = 8;
  localparam int NUM_SAVED = 15;

  localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
  localparam logic [7:0] SENSE_ABORTED = 8'h0B;

  // ****************************************************************
  // Link events, target to initiator
  // ****************************************************************
  typedef enum logic [2:0] {
    EV_NONE,
    EV_DISCONNECT,
    EV_SAVE_DATA,
    EV_MODIFY_DATA,
    EV_RESTORE,
    EV_RESELECT,
    EV_GOOD_STATUS
  } link_ev_e;

  // ****************************************************************
  // Phases that advance an active pointer
  // ****************************************************************
  typedef enum logic [1:0] {
    PH_CMD,
    PH_STATUS,
    PH_DATA
  } xfer_ph_e;

  typedef struct packed {
    logic [PTR_W-1:0] cmd;
    logic [PTR_W-1:0] status;
    logic [PTR_W-1:0] data;
  } ptr_set_s;

endpackage
`default_nettype wire

/* File: testbench/ptr_link_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module ptr_link_assertions (
  // Clock and reset
  input wire logic                      clock,
  input wire logic                      rst,
  // Link
  input wire logic                      ev_valid,
  input wire ptr_pkg::link_ev_e         ev,
  input wire logic [ptr_pkg::ID_W-1:0]  ev_target,
  input wire logic                      xfer_valid,
  input wire ptr_pkg::xfer_ph_e         xfer_ph,
  input wire logic                      sel_valid,
  input wire logic                      sel_abort_msg,
  input wire logic                      abort_task,
  input wire logic [ptr_pkg::ID_W-1:0]  abort_target
);
  // ********
  // Link checks
  // ********
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  chk_abort_cause: assert property (abort_task |-> $past(ev_valid) &&
    $past(ev) == ptr_pkg::EV_RESELECT) else $error("abort without reselect");
  chk_abort_id: assert property (abort_task |-> abort_target == $past(ev_target))
    else $error("abort names wrong target");
  chk_resel_unknown: assert property (ev_valid && ev == ptr_pkg::EV_RESELECT &&
    ev_target == 4'hF |=> abort_task) else $error("no abort for unknown target");
  chk_abort_pulse: assert property (abort_task &&
    !(ev_valid && ev == ptr_pkg::EV_RESELECT) |=> !abort_task) else $error("abort held");
  chk_sel_pulse: assert property (sel_valid |=> !sel_valid)
    else $error("selection held");
  chk_ev_named: assert property (ev_valid |-> ev != ptr_pkg::EV_NONE)
    else $error("empty event");
  chk_xfer_phase: assert property (xfer_valid |->
    xfer_ph inside {ptr_pkg::PH_CMD, ptr_pkg::PH_STATUS, ptr_pkg::PH_DATA})
    else $error("bad phase");
  chk_quiet_release: assert property ($fell(rst) |->
    !ev_valid && !sel_valid && !abort_task && !xfer_valid) else $error("busy at release");

  cover property (abort_task);
  cover property (sel_valid && !sel_abort_msg);
  cover property (ev_valid && ev == ptr_pkg::EV_RESTORE);
endmodule
`default_nettype wire

/* File: testbench/test_scsi_task_pointer_manager.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module test_scsi_task_pointer_manager;
  logic              clock, rst, task_load, task_retry, send_abort_msg;
  logic              req_valid, xfer_req, data_parity_err;
  logic              connected, good_status, check_cond, aborted_all, nexus_open, got_good;
  logic              got_abort;
  logic [3:0]        task_target, req_target, active_target, abort_id;
  logic [7:0]        task_tag, sense_key, sense_qual;
  logic [14:0]       saved_valid;
  logic [15:0]       req_arg, dsave;
  ptr_pkg::ptr_set_s task_start, active_ptr, exp;
  ptr_pkg::link_ev_e req_ev;
  ptr_pkg::xfer_ph_e xfer_ph_req;
  int                failures, samples_checked, cycles, seed;

  ptr_link_if link ();
  ptr_initiator i_ptr_initiator (.clock, .rst, .link, .task_load, .task_target, .task_tag,
    .task_start, .task_retry, .send_abort_msg, .active_ptr, .active_target, .connected,
    .good_status, .saved_valid);
  ptr_target i_ptr_target (.clock, .rst, .link, .req_valid, .req_ev, .req_target, .req_arg,
    .xfer_req, .xfer_ph_req, .data_parity_err, .check_cond, .sense_key, .sense_qual,
    .aborted_all, .nexus_open);
  ptr_link_assertions i_chk (.clock, .rst, .ev_valid(link.ev_valid), .ev(link.ev),
    .ev_target(link.ev_target), .xfer_valid(link.xfer_valid), .xfer_ph(link.xfer_ph),
    .sel_valid(link.sel_valid), .sel_abort_msg(link.sel_abort_msg),
    .abort_task(link.abort_task), .abort_target(link.abort_target));

  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end

  // ********
  // Pulse catchers and hang guard
  // ********
  always @(posedge clock) begin
    cycles++;
    if (good_status === 1'b1) got_good <= 1'b1;
    if (link.abort_task === 1'b1) abort_id <= link.abort_target;
    if (aborted_all === 1'b1) got_abort <= 1'b1;
    if (cycles == 3000) begin
      failures++;
      close_out;
    end
  end

  task automatic close_out;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Expected pointers after one byte in phase k
  function automatic ptr_pkg::ptr_set_s step(ptr_pkg::ptr_set_s p, int k);
    ptr_pkg::ptr_set_s r;
    r = p;
    if (k == 0) r.cmd = p.cmd + 16'h0001;
    else if (k == 1) r.status = p.status + 16'h0001;
    else r.data = p.data + 16'h0001;
    return r;
  endfunction

  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic send(ptr_pkg::link_ev_e e, logic [3:0] t, logic [15:0] a);
    req_valid = 1;
    req_ev = e;
    req_target = t;
    req_arg = a;
    @(negedge clock);
    req_valid = 0;
    cyc(3);
  endtask

  task automatic load(logic [3:0] t, logic [7:0] tag);
    task_target = t;
    task_tag = tag;
    task_start = {16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
    exp = task_start;
    task_load = 1;
    @(negedge clock);
    task_load = 0;
    cyc(3);
  endtask

  // One byte per cycle in a random phase
  task automatic bytes(int n);
    int k;
    repeat (n) begin
      k = {$random(seed)} % 3;
      xfer_ph_req = ptr_pkg::xfer_ph_e'(k);
      xfer_req = 1;
      exp = step(exp, k);
      @(negedge clock);
    end
    xfer_req = 0;
    cyc(3);
  endtask

  initial begin
    seed = 31071;
    {failures, samples_checked, cycles} = '0;
    {rst, got_good, abort_id} = '1;
    {task_load, task_retry, send_abort_msg, req_valid, xfer_req, data_parity_err} = '0;
    got_abort = 1'b0;
    {task_target, req_target, task_tag, req_arg, task_start} = '0;
    req_ev = ptr_pkg::EV_NONE;
    xfer_ph_req = ptr_pkg::PH_CMD;
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst = 0;
    `CHK("idle", 1'b0, connected)
    load(4'h2, 8'h11);
    `CHK("loaded", exp, active_ptr)
    `CHK("slots", 15'h0004, saved_valid)
    `CHK("target", 4'h2, active_target)
    `CHK("open", 1'b1, nexus_open)
    bytes(20);
    `CHK("advance", exp, active_ptr)
    task_retry = 1;
    @(negedge clock);
    task_retry = 0;
    cyc(3);
    `CHK("retry", task_start, active_ptr)
    exp = task_start;
    bytes(9);
    send(ptr_pkg::EV_SAVE_DATA, 4'h2, 16'h0000);
    dsave = exp.data + 16'hFFFD;
    bytes(5);
    send(ptr_pkg::EV_MODIFY_DATA, 4'h2, 16'hFFFD);
    send(ptr_pkg::EV_DISCONNECT, 4'h2, 16'h0000);
    `CHK("detached", 1'b0, connected)
    send(ptr_pkg::EV_RESELECT, 4'h2, 16'h0000);
    exp = task_start;
    exp.data = dsave;
    `CHK("resumed", exp, active_ptr)
    `CHK("rejoined", 1'b1, connected)
    bytes(4);
    req_target = 4'h2;
    data_parity_err = 1;
    @(negedge clock);
    data_parity_err = 0;
    cyc(3);
    `CHK("restored", task_start, active_ptr)
    got_good = 0;
    send(ptr_pkg::EV_GOOD_STATUS, 4'h2, 16'h0000);
    `CHK("good", 1'b1, got_good)
    `CHK("freed", 15'h0000, saved_valid)
    `CHK("closed", 1'b0, nexus_open)
    send(ptr_pkg::EV_RESELECT, 4'h9, 16'h0000);
    `CHK("abort9", 4'h9, abort_id)
    send(ptr_pkg::EV_RESELECT, 4'hF, 16'h0000);
    `CHK("abort15", 4'hF, abort_id)
    load(4'h4, 8'h5A);
    send(ptr_pkg::EV_DISCONNECT, 4'h4, 16'h0000);
    load(4'h4, 8'h5A);
    `CHK("check", 1'b1, check_cond)
    `CHK("key", ptr_pkg::SENSE_ABORTED, sense_key)
    `CHK("qual", 8'h5A, sense_qual)
    `CHK("abort all", 1'b1, got_abort)
    `CHK("dropped", 1'b0, nexus_open)
    close_out;
  end
endmodule
`default_nettype wire
